// File: spc_param_store.sv
// parameter store of the proximity and ambient sensor, wishbone slave
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "spc_consts.svh"
// Summary of operation
// R1: the answering bus address changes to the pending address only on a set-address command.
// R2: auxiliary enable bit 6 makes auxiliary results land in the auxiliary high and low bytes.
// R3: ambient infrared enable bit 5 makes its results land in the infrared byte pair.
// R4: ambient visible enable bit 4 makes its results land in the visible byte pair.
// R5: bits 0 to 2 enable proximity channels one to three, each with its own byte pair.
// R6: bits 6 to 4 of the first LED select choose the LEDs for the second proximity measurement.
// R7: bits 2 to 0 of the first LED select choose the LEDs for the first proximity measurement.
// R8: each LED field is a bitmask, bit 0 LED1, bit 1 LED2, bit 2 LED3, zero drives none.
// R9: on variants with fewer drivers the host keeps absent LED bits cleared.
// R10: bits 2 to 0 of the second LED select serve the third measurement, resetting to LED3 only.
// R11: a set alignment bit reports the low 16 of 17 converter bits, clear the upper 16.
// R12: alignment bits 4, 5 and 6 belong to proximity channels one, two and three.
// R13: the host leaves the reserved parameter at 0x1B at zero.
// R14: written parameters hold until rewritten or reset.
module spc_param_store
  import spc_pkg::*;
#(
  parameter int ADC_W = `SPC_ADC_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic [ADC_W-1:0]  adc_data_i,
  input  wire logic [2:0]        adc_ch_i,
  input  wire logic              adc_valid_i,
  input  wire logic [2:0]        meas_slot_i,
  output logic      [6:0]        bus_addr_o,
  output logic      [2:0]        led_drive_o,
  output logic      [5:0]        ch_en_o,
  output logic      [7:0]        led_recovery_time_o,
  output logic      [7:0]        ir_counter_o,
  output logic      [7:0]        ir_gain_o,
  output logic      [7:0]        ir_misc_o
);
  typedef struct packed {
    logic [7:0]  pend_addr;
    logic [7:0]  act_addr;
    logic [7:0]  measurement_channel_list;
    logic [7:0]  led12;
    logic [7:0]  led3;
    logic [7:0]  align;
    logic [7:0]  rsvd1b;
    logic [7:0]  led_recovery_time;
    logic [7:0]  ir_cnt;
    logic [7:0]  ir_gain;
    logic [7:0]  ir_misc;
    logic [95:0] results;
    logic [2:0]  led_drv;
    logic [31:0] rdata;
    logic        ack;
  } spc_store_t;

  spc_store_t   s_q, s_d;
  logic [7:0]   wb;
  logic         wr_en;
  logic [7:0]   rd;
  logic [2:0]   led_sel;
  logic [2:0]   meas_a, meas_b;
  spc_meas_if   mi();

  // two-stage sync of the measurement slot pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meas_a <= 3'b000;
      meas_b <= 3'b000;
    end else begin
      meas_a <= meas_slot_i;
      meas_b <= meas_a;
    end
  end

  assign mi.start     = 1'b0;
  assign mi.ch_en     = {s_q.measurement_channel_list[`SPC_BIT_AUX], s_q.measurement_channel_list[`SPC_BIT_IR],
                         s_q.measurement_channel_list[`SPC_BIT_VIS], s_q.measurement_channel_list[2:0]}; // R2 R3 R4 R5
  assign mi.align     = s_q.align[`SPC_ALIGN_LSB +: 3]; // R12
  assign mi.adc_data  = adc_data_i[16:0];
  assign mi.adc_ch    = adc_ch_i;
  assign mi.adc_valid = adc_valid_i;

  spc_capture u_cap (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .m     (mi)
  );

  assign wb    = dat_i[7:0];
  assign wr_en = cyc_i && stb_i && we_i && sel_i[0] && !s_q.ack;

  always_comb begin
    // LED mask picked per active measurement slot
    if (meas_b[2])
      led_sel = s_q.led3[2:0]; // R10
    else if (meas_b[1])
      led_sel = s_q.led12[`SPC_LED2_MSB:`SPC_LED2_LSB]; // R6
    else if (meas_b[0])
      led_sel = s_q.led12[2:0]; // R7
    else
      led_sel = 3'b000;
  end

  always_comb begin
    rd = `SPC_RST_ZERO;
    if (adr_i[7:2] == `SPC_OFF_BUS_ADDR)
      rd = s_q.pend_addr;
    else if (adr_i[7:2] == `SPC_OFF_MEASUREMENT_CHANNEL_LIST)
      rd = s_q.measurement_channel_list;
    else if (adr_i[7:2] == `SPC_OFF_LED12)
      rd = s_q.led12;
    else if (adr_i[7:2] == `SPC_OFF_LED3)
      rd = s_q.led3;
    else if (adr_i[7:2] == `SPC_OFF_ALIGN)
      rd = s_q.align;
    else if (adr_i[7:2] == `SPC_OFF_RSVD1B)
      rd = s_q.rsvd1b;
    else if (adr_i[7:2] == `SPC_OFF_LED_RECOVERY_TIME)
      rd = s_q.led_recovery_time;
    else if (adr_i[7:2] == `SPC_OFF_IR_COUNTER)
      rd = s_q.ir_cnt;
    else if (adr_i[7:2] == `SPC_OFF_IR_GAIN)
      rd = s_q.ir_gain;
    else if (adr_i[7:2] == `SPC_OFF_IR_MISC)
      rd = s_q.ir_misc;
    else if (adr_i[7:2] == `SPC_OFF_ACTIVE_ADDR)
      rd = s_q.act_addr;
    else if (adr_i[7:2] >= `SPC_OFF_RESULT_BASE && adr_i[7:2] < 8'h3C)
      rd = s_q.results[8*(adr_i[5:2])+:8];
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = cyc_i && stb_i && !s_q.ack;
    s_d.led_drv = led_sel; // R8
    if (s_d.ack)
      s_d.rdata = {24'h000000, rd};
    // store the low data byte; byte 0 lane only
    if (wr_en) begin
      if (adr_i[7:2] == `SPC_OFF_BUS_ADDR)
        s_d.pend_addr = wb; // R1
      else if (adr_i[7:2] == `SPC_OFF_MEASUREMENT_CHANNEL_LIST)
        s_d.measurement_channel_list = wb; // R14
      else if (adr_i[7:2] == `SPC_OFF_LED12)
        s_d.led12 = wb;
      else if (adr_i[7:2] == `SPC_OFF_LED3)
        s_d.led3 = wb;
      else if (adr_i[7:2] == `SPC_OFF_ALIGN)
        s_d.align = wb;
      else if (adr_i[7:2] == `SPC_OFF_RSVD1B)
        s_d.rsvd1b = wb; // R13
      else if (adr_i[7:2] == `SPC_OFF_LED_RECOVERY_TIME)
        s_d.led_recovery_time = wb;
      else if (adr_i[7:2] == `SPC_OFF_IR_COUNTER)
        s_d.ir_cnt = wb;
      else if (adr_i[7:2] == `SPC_OFF_IR_GAIN)
        s_d.ir_gain = wb;
      else if (adr_i[7:2] == `SPC_OFF_IR_MISC)
        s_d.ir_misc = wb;
      else if (adr_i[7:2] == `SPC_OFF_CMD && wb == `SPC_CMD_SET_ADDR)
        s_d.act_addr = s_q.pend_addr; // R1
    end
    if (mi.wr)
      s_d.results[8*mi.wr_idx+:8] = mi.wr_byte; // R2 R3 R4 R5
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.pend_addr <= `SPC_RST_BUS_ADDR;
      s_q.act_addr  <= `SPC_RST_BUS_ADDR;
      s_q.measurement_channel_list    <= `SPC_RST_ZERO;
      s_q.led12     <= `SPC_RST_ZERO;
      s_q.led3      <= `SPC_RST_LED3; // R10
      s_q.align     <= `SPC_RST_ZERO;
      s_q.rsvd1b    <= `SPC_RST_ZERO;
      s_q.led_recovery_time   <= `SPC_RST_ZERO;
      s_q.ir_cnt    <= `SPC_RST_ZERO;
      s_q.ir_gain   <= `SPC_RST_ZERO;
      s_q.ir_misc   <= `SPC_RST_ZERO;
      s_q.results   <= '0;
      s_q.led_drv   <= 3'b000;
      s_q.rdata     <= 32'h00000000;
      s_q.ack       <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o        = s_q.rdata;
  assign ack_o        = s_q.ack;
  assign bus_addr_o   = s_q.act_addr[6:0];
  assign led_drive_o  = s_q.led_drv;
  assign ch_en_o      = mi.ch_en;
  assign led_recovery_time_o    = s_q.led_recovery_time;
  assign ir_counter_o = s_q.ir_cnt;
  assign ir_gain_o    = s_q.ir_gain;
  assign ir_misc_o    = s_q.ir_misc;

  // request helpers for the checks below
  logic       take_rd;
  logic [5:0] widx;
  assign take_rd = cyc_i && stb_i && !we_i && !s_q.ack;
  assign widx    = adr_i[7:2];

  // answering address
  addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    !(wr_en && widx == `SPC_OFF_CMD) |=> $stable(s_q.act_addr))
    else $error("active address moved without command");
  addr_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    wr_en && widx == `SPC_OFF_CMD && wb == `SPC_CMD_SET_ADDR
    |=> s_q.act_addr == $past(s_q.pend_addr))
    else $error("address command not applied");
  cmd_other_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    wr_en && widx == `SPC_OFF_CMD && wb != `SPC_CMD_SET_ADDR |=> $stable(s_q.act_addr))
    else $error("other command moved address");
  pend_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    !(wr_en && widx == `SPC_OFF_BUS_ADDR) |=> $stable(s_q.pend_addr))
    else $error("pending address moved without write");
  pend_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    wr_en && widx == `SPC_OFF_BUS_ADDR |=> s_q.pend_addr == $past(wb))
    else $error("pending address write lost");

  // led drive per slot
  led_two_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    meas_b == 3'b010 |=> led_drive_o == $past(s_q.led12[6:4]))
    else $error("second slot led mask wrong");
  led_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    meas_b == 3'b001 |=> led_drive_o == $past(s_q.led12[2:0]))
    else $error("first slot led mask wrong");
  led_none_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    meas_b == 3'b000 |=> led_drive_o == 3'b000)
    else $error("led driven outside slot");
  led_three_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    meas_b[2] |=> led_drive_o == $past(s_q.led3[2:0]))
    else $error("third slot led mask wrong");

  // parameter writes land
  chl_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    wr_en && widx == `SPC_OFF_MEASUREMENT_CHANNEL_LIST |=> s_q.measurement_channel_list == $past(wb))
    else $error("channel list write lost");
  led12_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    wr_en && widx == `SPC_OFF_LED12 |=> s_q.led12 == $past(wb))
    else $error("first led select write lost");
  led3_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    wr_en && widx == `SPC_OFF_LED3 |=> s_q.led3 == $past(wb))
    else $error("second led select write lost");
  align_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    wr_en && widx == `SPC_OFF_ALIGN |=> s_q.align == $past(wb))
    else $error("alignment write lost");
  rec_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    wr_en && widx == `SPC_OFF_LED_RECOVERY_TIME |=> s_q.led_recovery_time == $past(wb))
    else $error("recovery time write lost");
  irc_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    wr_en && widx == `SPC_OFF_IR_COUNTER |=> s_q.ir_cnt == $past(wb))
    else $error("ir counter write lost");
  gain_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    wr_en && widx == `SPC_OFF_IR_GAIN |=> s_q.ir_gain == $past(wb))
    else $error("ir gain write lost");
  misc_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    wr_en && widx == `SPC_OFF_IR_MISC |=> s_q.ir_misc == $past(wb))
    else $error("ir misc write lost");

  // parameters hold without a write
  param_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    !wr_en |=> $stable(s_q.measurement_channel_list) && $stable(s_q.led12) && $stable(s_q.led_recovery_time))
    else $error("parameter changed without write");
  led3_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    !wr_en |=> $stable(s_q.led3) && $stable(s_q.align))
    else $error("select or alignment changed without write");
  ir_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    !wr_en |=> $stable(s_q.ir_cnt) && $stable(s_q.ir_gain) && $stable(s_q.ir_misc))
    else $error("ir setting changed without write");
  sel_skip_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    cyc_i && stb_i && we_i && !sel_i[0] |=> $stable(s_q.measurement_channel_list) && $stable(s_q.led3))
    else $error("write without lane 0 landed");

  // read data follows the register
  rd_pend_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    take_rd && widx == `SPC_OFF_BUS_ADDR |=> dat_o[7:0] == $past(s_q.pend_addr))
    else $error("pending address read wrong");
  rd_act_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    take_rd && widx == `SPC_OFF_ACTIVE_ADDR |=> dat_o[7:0] == $past(s_q.act_addr))
    else $error("active address read wrong");
  rd_chl_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    take_rd && widx == `SPC_OFF_MEASUREMENT_CHANNEL_LIST |=> dat_o[7:0] == $past(s_q.measurement_channel_list))
    else $error("channel list read wrong");
  rd_led12_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    take_rd && widx == `SPC_OFF_LED12 |=> dat_o[7:0] == $past(s_q.led12))
    else $error("first led select read wrong");
  rd_led3_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    take_rd && widx == `SPC_OFF_LED3 |=> dat_o[7:0] == $past(s_q.led3))
    else $error("second led select read wrong");
  rd_align_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    take_rd && widx == `SPC_OFF_ALIGN |=> dat_o[7:0] == $past(s_q.align))
    else $error("alignment read wrong");
  rd_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    take_rd && widx == `SPC_OFF_RSVD1B |=> dat_o[7:0] == $past(s_q.rsvd1b))
    else $error("reserved parameter read wrong");
  rd_rec_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    take_rd && widx == `SPC_OFF_LED_RECOVERY_TIME |=> dat_o[7:0] == $past(s_q.led_recovery_time))
    else $error("recovery time read wrong");
  rd_gain_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    take_rd && widx == `SPC_OFF_IR_GAIN |=> dat_o[7:0] == $past(s_q.ir_gain))
    else $error("ir gain read wrong");
  rd_misc_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    take_rd && widx == `SPC_OFF_IR_MISC |=> dat_o[7:0] == $past(s_q.ir_misc))
    else $error("ir misc read wrong");
  rd_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");

  // bus handshake
  ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
  ack_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");

  // channel and result mapping
  align_map_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    mi.align == s_q.align[6:4])
    else $error("alignment bits misplaced");
  chan_map_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    ch_en_o[5] == s_q.measurement_channel_list[6] && ch_en_o[4] == s_q.measurement_channel_list[5])
    else $error("channel enable map wrong");
  res_ro_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    !mi.wr |=> $stable(s_q.results))
    else $error("result bytes moved without capture");

  cmd_c: cover property (@(posedge clk_i) wr_en && widx == `SPC_OFF_CMD);
  addr_set_c: cover property (@(posedge clk_i) wr_en && widx == `SPC_OFF_CMD && wb == `SPC_CMD_SET_ADDR);
  led3_c: cover property (@(posedge clk_i) meas_b[2] && led_drive_o != 3'b000);
  res_c: cover property (@(posedge clk_i) mi.wr);
endmodule : spc_param_store

// File: spc_consts.svh
// constants for the sensor parameter store
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_OFF_BUS_ADDR     8'h00
`define SPC_OFF_MEASUREMENT_CHANNEL_LIST       8'h01
`define SPC_OFF_LED12        8'h02
`define SPC_OFF_LED3         8'h03
`define SPC_OFF_ALIGN        8'h05
`define SPC_OFF_RSVD1B       8'h1B
`define SPC_OFF_LED_RECOVERY_TIME      8'h1C
`define SPC_OFF_IR_COUNTER   8'h1D
`define SPC_OFF_IR_GAIN      8'h1E
`define SPC_OFF_IR_MISC      8'h1F
`define SPC_OFF_CMD          8'h20
`define SPC_OFF_ACTIVE_ADDR  8'h21
`define SPC_OFF_MEAS_CTRL    8'h22
`define SPC_OFF_RESULT_BASE  8'h30
`define SPC_RST_BUS_ADDR     8'h00
`define SPC_RST_ZERO         8'h00
`define SPC_RST_LED3         8'h04
`define SPC_CMD_SET_ADDR     8'h11
`define SPC_BIT_AUX          6
`define SPC_BIT_IR           5
`define SPC_BIT_VIS          4
`define SPC_ALIGN_LSB        4
`define SPC_LED2_MSB         6
`define SPC_LED2_LSB         4
`define SPC_LED_W            3
`define SPC_ADC_W            17
`define SPC_NUM_CH           6
`endif

// File: spc_pkg.sv
// types for the sensor parameter store
package spc_pkg;
  typedef enum logic [2:0] {
    SPC_IDLE = 3'b001,
    SPC_MEAS = 3'b010,
    SPC_DONE = 3'b100
  } spc_state_t;
endpackage : spc_pkg

// File: spc_meas_if.sv
// link between parameter store and result capture
`timescale 1ns/1ps
interface spc_meas_if;
  logic        start;
  logic [5:0]  ch_en;
  logic [2:0]  align;
  logic [16:0] adc_data;
  logic [2:0]  adc_ch;
  logic        adc_valid;
  logic        wr;
  logic [3:0]  wr_idx;
  logic [7:0]  wr_byte;
  modport store (output start, ch_en, align, adc_data, adc_ch, adc_valid,
                 input wr, wr_idx, wr_byte);
  modport capture (input start, ch_en, align, adc_data, adc_ch, adc_valid,
                   output wr, wr_idx, wr_byte);
endinterface : spc_meas_if

// File: spc_capture.sv
// captures converter results into result byte pairs
`timescale 1ns/1ps
`include "spc_consts.svh"
module spc_capture
  import spc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  spc_meas_if.capture m
);
  typedef struct packed {
    spc_state_t st;
    logic [15:0] word;
    logic [3:0]  idx;
    logic        hi;
    logic        wr;
  } spc_cap_t;
  spc_cap_t s_q, s_d;
  logic [15:0] aligned;

  always_comb begin
    // proximity channels 0..2 use their own alignment bit, others take upper bits
    if (m.adc_ch < 3'd3 && m.align[m.adc_ch[1:0]])
      aligned = m.adc_data[15:0]; // R11
    else
      aligned = m.adc_data[16:1]; // R11
    s_d = s_q;
    s_d.wr = 1'b0;
    case (s_q.st)
      SPC_IDLE: begin
        if (m.adc_valid && m.adc_ch < 3'(`SPC_NUM_CH) && m.ch_en[m.adc_ch]) begin // R2 R3 R4 R5
          s_d.word = aligned;
          s_d.idx  = {m.adc_ch, 1'b0};
          s_d.hi   = 1'b0;
          s_d.st   = SPC_MEAS;
        end
      end
      SPC_MEAS: begin
        s_d.wr = 1'b1;
        if (s_q.hi)
          s_d.st = SPC_DONE;
        s_d.hi = 1'b1;
      end
      SPC_DONE: begin
        s_d.st = SPC_IDLE;
      end
      default: s_d.st = SPC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.st   <= SPC_IDLE;
      s_q.word <= 16'h0000;
      s_q.idx  <= 4'h0;
      s_q.hi   <= 1'b0;
      s_q.wr   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // low byte then high byte of the channel pair
  assign m.wr      = s_q.wr;
  assign m.wr_idx  = s_q.idx | {3'b000, s_q.st[2]};
  assign m.wr_byte = s_q.st[2] ? s_q.word[15:8] : s_q.word[7:0];

  meas_pair_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    s_q.st == SPC_MEAS && s_q.hi |=> s_q.st == SPC_DONE && m.wr)
    else $error("result pair not completed");
  pair_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    s_q.st == SPC_MEAS && s_q.wr |-> !m.wr_idx[0] && m.wr_byte == s_q.word[7:0])
    else $error("low byte not written first");
  align_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    m.adc_ch == 3'd0 && m.align[0] |-> aligned == m.adc_data[15:0])
    else $error("low alignment not applied");
  align_up_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    m.adc_ch == 3'd5 |-> aligned == m.adc_data[16:1])
    else $error("upper alignment not applied");
  no_cap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    s_q.st == SPC_IDLE && m.adc_valid && m.adc_ch < 3'd6 && !m.ch_en[m.adc_ch]
    |=> s_q.st == SPC_IDLE)
    else $error("disabled channel captured");
  cap_go_c: cover property (@(posedge clk_i) s_q.st == SPC_DONE);
endmodule : spc_capture

// File: spc_conv_model.sv
// converter model that returns one result per request
`timescale 1ns/1ps
module spc_conv_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [2:0]  ch_i,
  input  wire logic [16:0] val_i,
  input  wire logic [3:0]  lat_i,
  output logic      [16:0] adc_data_o,
  output logic      [2:0]  adc_ch_o,
  output logic             adc_valid_o
);
  logic [4:0]  cnt_q;
  logic [16:0] val_q;
  initial begin
    cnt_q = '0;
    adc_valid_o = 1'b0;
    adc_data_o = 17'h0AAAA;
    adc_ch_o = 3'h7;
  end
  always @(posedge clk_i) begin
    adc_valid_o <= 1'b0;
    // data not held after the pulse
    if (adc_valid_o) adc_data_o <= ~adc_data_o;
    if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
      if (cnt_q == 5'h01) begin
        adc_valid_o <= 1'b1;
        adc_data_o <= val_q;
      end
    end else if (go_i) begin
      cnt_q <= {1'b0, lat_i} + 5'h01;
      val_q <= val_i;
      adc_ch_o <= ch_i;
    end
  end
endmodule : spc_conv_model

// File: sensor_channel_param_config_tb.sv
// self-checking bench for the sensor parameter store
`timescale 1ns/1ps
module sensor_channel_param_config_tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, adc_valid, go;
  logic [7:0]  adr_i, rd, a;
  logic [3:0]  sel_i, go_lat, wsel;
  logic [31:0] dat_i, dat_o;
  logic [16:0] adc_data, go_val, dv;
  logic [2:0]  adc_ch, meas_slot_i, led_drive_o, go_ch;
  logic [6:0]  bus_addr_o;
  logic [5:0]  ch_en_o;
  logic [7:0]  led_recovery_time_o, ir_counter_o, ir_gain_o, ir_misc_o, al, l12, l3;
  logic [15:0] last;
  int          error_cnt, n_compared, s;
  logic [7:0]  offs [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h1C, 8'h1D, 8'h1E, 8'h1F};
  logic [7:0]  msk [9] = '{8'hFF, 8'h77, 8'h77, 8'h07, 8'h70, 8'hFF, 8'h70, 8'h07, 8'h20};
  logic [7:0]  val [9];
  spc_param_store uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .adc_data_i(adc_data), .adc_ch_i(adc_ch), .adc_valid_i(adc_valid),
    .meas_slot_i(meas_slot_i), .bus_addr_o(bus_addr_o), .led_drive_o(led_drive_o),
    .ch_en_o(ch_en_o), .led_recovery_time_o(led_recovery_time_o), .ir_counter_o(ir_counter_o),
    .ir_gain_o(ir_gain_o), .ir_misc_o(ir_misc_o));
  spc_conv_model conv (.clk_i(clk_i), .go_i(go), .ch_i(go_ch), .val_i(go_val),
    .lat_i(go_lat), .adc_data_o(adc_data), .adc_ch_o(adc_ch), .adc_valid_o(adc_valid));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; sel_i <= wsel;
    adr_i <= {idx[5:0], 2'b00}; dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o[7:0];
    cyc_i <= 1'b0; stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      error_cnt++;
      $display("BAD ack expected 1 seen timeout");
      finish_test();
    end
  endtask : wb
  function automatic logic [15:0] exp_res(input int ch, input logic [7:0] alg,
                                         input logic [16:0] d);
    return (ch < 3 && alg[4+ch]) ? d[15:0] : d[16:1];
  endfunction : exp_res
  task conv_go(input logic [2:0] ch, input logic [16:0] d);
    int n;
    @(posedge clk_i);
    go <= 1'b1; go_ch <= ch; go_val <= d; go_lat <= 4'($urandom_range(3));
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    while (adc_valid !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    repeat (4) @(posedge clk_i);
    if (n >= 20) begin
      error_cnt++;
      $display("BAD adc valid expected 1 seen timeout");
      finish_test();
    end
  endtask : conv_go
  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h0;
    dat_i = 32'h0; meas_slot_i = 3'h0; go = 1'b0; go_ch = 3'h0; go_val = 17'h0; go_lat = 4'h0;
    error_cnt = 0; n_compared = 0;
    wsel = 4'hF;
    s = $urandom(32'h29db391b);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h03, 8'h00); chk("led3 reset", 16'h0004, {8'h0, rd});
    wb(1'b0, 8'h00, 8'h00); chk("addr reset", 16'h0000, {8'h0, rd});
    wb(1'b0, 8'h1B, 8'h00); chk("rsvd 1b", 16'h0000, {8'h0, rd});
    wb(1'b0, 8'h3C, 8'h00); chk("unmapped", 16'h0000, {8'h0, rd});
    $display("test reset done");
    a = 8'($urandom_range(8'h08, 8'h77));
    wb(1'b1, 8'h00, a);
    wb(1'b1, 8'h20, 8'h12);
    repeat (3) @(posedge clk_i);
    chk("addr before cmd", 16'h0000, {9'h0, bus_addr_o});
    wb(1'b1, 8'h20, 8'h11);
    repeat (3) @(posedge clk_i);
    chk("addr after cmd", {9'h0, a[6:0]}, {9'h0, bus_addr_o});
    wb(1'b0, 8'h21, 8'h00); chk("active addr", {8'h0, a}, {8'h0, rd});
    $display("test address done");
    // all three drivers present, so every LED bit may be set
    for (int k = 0; k < 3; k++) begin
      l12 = (k == 0) ? 8'h00 : (k == 1) ? 8'h77 : 8'($urandom) & 8'h77;
      l3 = (k == 0) ? 8'h00 : (k == 1) ? 8'h07 : 8'($urandom) & 8'h07;
      wb(1'b1, 8'h02, l12);
      wb(1'b1, 8'h03, l3);
      for (int i = 0; i < 3; i++) begin
        @(posedge clk_i);
        meas_slot_i <= 3'(1 << i);
        repeat (5) @(posedge clk_i);
        chk("led drive", {13'h0, i == 0 ? l12[2:0] : i == 1 ? l12[6:4] : l3[2:0]},
            {13'h0, led_drive_o});
      end
    end
    $display("test led done");
    for (int k = 0; k < 2; k++) begin
      al = (k == 0) ? 8'h70 : 8'($urandom) & 8'h70;
      wb(1'b1, 8'h05, al);
      wb(1'b1, 8'h01, 8'h77);
      for (int c = 0; c < 6; c++) begin
        dv = (k == 0 && c == 0) ? 17'h1FFFE : 17'($urandom);
        conv_go(3'(c), dv);
        last = exp_res(c, al, dv);
        wb(1'b0, 8'(8'h30 + 2 * c), 8'h00);
        chk("result low", {8'h0, last[7:0]}, {8'h0, rd});
        wb(1'b0, 8'(8'h31 + 2 * c), 8'h00);
        chk("result high", {8'h0, last[15:8]}, {8'h0, rd});
      end
    end
    wb(1'b1, 8'h01, 8'h37);
    conv_go(3'h5, ~dv);
    wb(1'b0, 8'h3A, 8'h00); chk("aux disabled", {8'h0, last[7:0]}, {8'h0, rd});
    $display("test results done");
    for (int i = 0; i < 9; i++) begin
      val[i] = 8'($urandom) & msk[i];
      wb(1'b1, offs[i], val[i]);
    end
    wb(1'b0, 8'h1B, 8'h00); chk("rsvd 1b", 16'h0000, {8'h0, rd});
    chk("ch en", {10'h0, val[1][6:4], val[1][2:0]}, {10'h0, ch_en_o});
    chk("led_recovery_time", {8'h0, val[5]}, {8'h0, led_recovery_time_o});
    chk("ir counter", {8'h0, val[6]}, {8'h0, ir_counter_o});
    chk("ir gain", {8'h0, val[7]}, {8'h0, ir_gain_o});
    chk("ir misc", {8'h0, val[8]}, {8'h0, ir_misc_o});
    wsel = 4'hE;
    wb(1'b1, 8'h1C, ~val[5]);
    wsel = 4'hF;
    chk("led_recovery_time lane off", {8'h0, val[5]}, {8'h0, led_recovery_time_o});
    conv_go(3'h1, 17'($urandom));
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, offs[i], 8'h00);
      chk("param readback", {8'h0, val[i]}, {8'h0, rd});
    end
    $display("test retention done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h03, 8'h00); chk("led3 after reset", 16'h0004, {8'h0, rd});
    wb(1'b0, 8'h02, 8'h00); chk("led12 after reset", 16'h0000, {8'h0, rd});
    chk("led_recovery_time after reset", 16'h0000, {8'h0, led_recovery_time_o});
    $display("test second reset done");
    finish_test();
  end
endmodule : sensor_channel_param_config_tb
